// ==== hw/ofl_osc_loop_ctrl.sv ====
// Oscillator and low-power frequency loop controller with AXI4-Lite registers
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
// Function
// - Clock output gated until ready flag set
// - Reset: oscillator enabled, 4MHz, run-in-standby and on-demand off
// - Enable zero stops oscillator in all modes
// - Active/idle: on-demand bit gates running
// - Standby: run-in-standby and on-demand select
// - Loop output tracks reference times ratio
// - Tuner runs only while loop enabled
// - Loop control fields other than enable writable only when disabled
// - Dither and ratio registers disable-protected
// - Protected fields taken with enabling write
module ofl_osc_loop_ctrl #(
	parameter int STARTUP_CYC = ofl_pkg::OFL_RC_STARTUP_CYC
) (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	// AXI4-Lite write address, data and response
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// System state and clock requests
	input  ofl_pkg::ofl_cpu_mode_t         cpuMode,
	input  wire logic                      periphRequest,
	input  wire logic                      refClkTick,
	input  wire logic                      loopClkTick,
	// Clock outputs
	output logic                           rcOscRun,
	output logic                           rcOscClkEn,
	output logic [1:0]                     rcOscFreqSel,
	output logic                           loopClkEn,
	output logic [ofl_pkg::OFL_TUNE_W-1:0] loopTune
);
	import ofl_pkg::*;

	// Start-up counter is eight bits wide and must count at least once
	if (STARTUP_CYC < 1 || STARTUP_CYC > 255) begin : g_badStartup
		$error("STARTUP_CYC out of range");
	end

	ofl_rc_ctrl_t             rcCtrl_ff;
	ofl_loop_ctrl_t           loopCtrl_ff;
	logic [OFL_DITH_W-1:0]    dither_ff;
	logic [OFL_RATIO_W-1:0]   ratio_ff;
	logic [7:0]               startCnt_ff;
	logic                     rcReady_ff;
	logic [OFL_RATIO_W+3:0]   loopCnt_ff;
	logic                     loopLocked_ff;
	logic [7:0]               awAddr_ff;
	logic                     awHeld_ff;
	logic [31:0]              wData_ff;
	logic [3:0]               wStrb_ff;
	logic                     wHeld_ff;
	logic                     rcWant;
	logic                     doWrite;
	logic [31:0]              wrMerged;
	logic [31:0]              rdWord;
	logic                     rdHit;

	// Byte-lane merge of new write data onto the old word
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
		input logic [31:0] newV, input logic [3:0] strb);
		logic [31:0] res;
		res = oldV;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = newV[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [31:0] regWord(input logic [7:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr)
			OFL_ADDR_RC_CTRL: begin
				v[OFL_RC_ENABLE_BIT]                 = rcCtrl_ff.enable;
				v[OFL_RC_FSEL_LSB +: 2]              = rcCtrl_ff.freqSel;
				v[OFL_RC_STDBY_BIT]                  = rcCtrl_ff.runInStandby;
				v[OFL_RC_ONDEM_BIT]                  = rcCtrl_ff.runOnDemand;
			end
			OFL_ADDR_STATUS: begin
				v[OFL_ST_RCRDY_BIT]                  = rcReady_ff;
				v[OFL_ST_LOOPRDY_BIT]                = loopLocked_ff;
			end
			OFL_ADDR_LOOP_CTL: begin
				v[OFL_LC_ENABLE_BIT]                 = loopCtrl_ff.enable;
				v[OFL_LC_BINARY_SEARCH_ENABLE_BIT]                  = loopCtrl_ff.binSearchEn;
				v[OFL_LC_SAFE_BIT]                   = loopCtrl_ff.safeMode;
				v[OFL_LC_DITHER_BIT]                 = loopCtrl_ff.ditherMode;
				v[OFL_LC_DIV_LSB +: OFL_DIV_W]       = loopCtrl_ff.divFactor;
			end
			OFL_ADDR_DITHER: v[OFL_DITH_W-1:0]       = dither_ff;
			OFL_ADDR_RATIO:  v[OFL_RATIO_W-1:0]      = ratio_ff;
			OFL_ADDR_TUNE:   v[OFL_TUNE_W-1:0]       = loopTune;
			default:         v                       = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic isMapped(input logic [7:0] addr);
		return addr == OFL_ADDR_RC_CTRL || addr == OFL_ADDR_STATUS ||
			addr == OFL_ADDR_LOOP_CTL || addr == OFL_ADDR_DITHER ||
			addr == OFL_ADDR_RATIO || addr == OFL_ADDR_TUNE;
	endfunction

	// Write channel capture: address and data may come in either order
	assign doWrite  = awHeld_ff && wHeld_ff && !s_axi_bvalid;
	assign wrMerged = mergeBytes(regWord(awAddr_ff), wData_ff, wStrb_ff);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld_ff     <= 1'b0;
			awAddr_ff     <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end else if (doWrite) begin
				awHeld_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wHeld_ff     <= 1'b0;
			wData_ff     <= 32'h0000_0000;
			wStrb_ff     <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= OFL_RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= isMapped(awAddr_ff) ? OFL_RESP_OKAY : OFL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one outstanding read, answered two cycles after address
	assign rdWord = regWord({s_axi_araddr[7:2], 2'b00});
	assign rdHit  = isMapped({s_axi_araddr[7:2], 2'b00});

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= OFL_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdWord;
				s_axi_rresp  <= rdHit ? OFL_RESP_OKAY : OFL_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Oscillator control register; reset leaves it on at 4MHz
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rcCtrl_ff <= '{runOnDemand: 1'b0, runInStandby: 1'b0,
				freqSel: OFL_FSEL_4MHZ, enable: 1'b1};
		end else if (doWrite && awAddr_ff == OFL_ADDR_RC_CTRL) begin
			rcCtrl_ff.enable       <= wrMerged[OFL_RC_ENABLE_BIT];
			rcCtrl_ff.freqSel      <= wrMerged[OFL_RC_FSEL_LSB +: 2];
			rcCtrl_ff.runInStandby <= wrMerged[OFL_RC_STDBY_BIT];
			rcCtrl_ff.runOnDemand  <= wrMerged[OFL_RC_ONDEM_BIT];
		end
	end

	// Run decision per CPU mode; standby without run-in-standby is request only
	always_comb begin
		rcWant = 1'b0;
		if (rcCtrl_ff.enable) begin
			case (cpuMode)
				OFL_CPU_ACTIVE, OFL_CPU_IDLE: begin
					rcWant = !rcCtrl_ff.runOnDemand || periphRequest;
				end
				OFL_CPU_STANDBY: begin
					rcWant = rcCtrl_ff.runInStandby ?
						(!rcCtrl_ff.runOnDemand || periphRequest) : periphRequest;
				end
				default: rcWant = 1'b0;
			endcase
		end
	end

	// Ready only after the start-up count; it drops at once on stop, which is
	// what software polls before re-enabling
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			startCnt_ff <= 8'h00;
			rcReady_ff  <= 1'b0;
			rcOscRun    <= 1'b0;
		end else begin
			rcOscRun <= rcWant;
			if (!rcWant) begin
				startCnt_ff <= 8'h00;
				rcReady_ff  <= 1'b0;
			end else if (startCnt_ff < 8'(STARTUP_CYC)) begin
				startCnt_ff <= startCnt_ff + 8'h01;
			end else begin
				rcReady_ff <= 1'b1;
			end
		end
	end

	// Clock delivered only once ready
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rcOscClkEn   <= 1'b0;
			rcOscFreqSel <= OFL_FSEL_4MHZ;
		end else begin
			rcOscClkEn   <= rcReady_ff && rcWant;
			rcOscFreqSel <= rcCtrl_ff.freqSel;
		end
	end

	// Loop control: protected fields move only when the loop is off, or in the
	// write that turns it on; a disabling write touches only enable
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			loopCtrl_ff <= '0;
		end else if (doWrite && awAddr_ff == OFL_ADDR_LOOP_CTL) begin
			loopCtrl_ff.enable <= wrMerged[OFL_LC_ENABLE_BIT];
			if (!loopCtrl_ff.enable) begin
				loopCtrl_ff.binSearchEn <= wrMerged[OFL_LC_BINARY_SEARCH_ENABLE_BIT];
				loopCtrl_ff.safeMode    <= wrMerged[OFL_LC_SAFE_BIT];
				loopCtrl_ff.ditherMode  <= wrMerged[OFL_LC_DITHER_BIT];
				loopCtrl_ff.divFactor   <= wrMerged[OFL_LC_DIV_LSB +: OFL_DIV_W];
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dither_ff <= OFL_DITH_RST;
			ratio_ff  <= OFL_RATIO_RST;
		end else if (doWrite && !loopCtrl_ff.enable) begin
			if (awAddr_ff == OFL_ADDR_DITHER) begin
				dither_ff <= wrMerged[OFL_DITH_W-1:0];
			end
			if (awAddr_ff == OFL_ADDR_RATIO) begin
				ratio_ff <= wrMerged[OFL_RATIO_W-1:0];
			end
		end
	end

	// Tuner: counts loop ticks per reference tick and steers the tune word so
	// the count meets ratio; the step is one code, so lock is slow but smooth
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			loopCnt_ff    <= '0;
			loopTune      <= '0;
			loopLocked_ff <= 1'b0;
			loopClkEn     <= 1'b0;
		end else if (!loopCtrl_ff.enable) begin
			loopCnt_ff    <= '0;
			loopLocked_ff <= 1'b0;
			loopClkEn     <= 1'b0;
		end else begin
			loopClkEn <= 1'b1;
			if (refClkTick) begin
				loopCnt_ff    <= '0;
				loopLocked_ff <= loopCnt_ff[OFL_RATIO_W-1:0] == ratio_ff;
				if (loopCnt_ff < {4'h0, ratio_ff} && loopTune != '1) begin
					loopTune <= loopTune + 1'b1;
				end else if (loopCnt_ff > {4'h0, ratio_ff} && loopTune != '0) begin
					loopTune <= loopTune - 1'b1;
				end
			end else if (loopClkTick && loopCnt_ff != '1) begin
				loopCnt_ff <= loopCnt_ff + 1'b1;
			end
		end
	end

	property p_rcOffWhenDisabled;
		@(posedge mclk) disable iff (sys_rst)
		!rcCtrl_ff.enable |=> !rcOscRun && !rcOscClkEn;
	endproperty
	a_rcOffWhenDisabled: assert property (p_rcOffWhenDisabled)
		else $error("oscillator runs while disabled");

	property p_clkNeedsReady;
		@(posedge mclk) disable iff (sys_rst)
		rcOscClkEn |-> $past(rcReady_ff);
	endproperty
	a_clkNeedsReady: assert property (p_clkNeedsReady)
		else $error("clock delivered before ready");

	property p_activeAlwaysRun;
		@(posedge mclk) disable iff (sys_rst)
		(rcCtrl_ff.enable && !rcCtrl_ff.runOnDemand && cpuMode != OFL_CPU_STANDBY)
			|=> rcOscRun;
	endproperty
	a_activeAlwaysRun: assert property (p_activeAlwaysRun)
		else $error("oscillator not running in active mode");

	property p_standbyNoReqStop;
		@(posedge mclk) disable iff (sys_rst)
		(cpuMode == OFL_CPU_STANDBY && !rcCtrl_ff.runInStandby && !periphRequest)
			|=> !rcOscRun;
	endproperty
	a_standbyNoReqStop: assert property (p_standbyNoReqStop)
		else $error("oscillator runs in standby without request");

	property p_readyAfterStart;
		@(posedge mclk) disable iff (sys_rst)
		$rose(rcOscRun) |-> ##[1:300] (rcReady_ff || !rcOscRun);
	endproperty
	a_readyAfterStart: assert property (p_readyAfterStart)
		else $error("oscillator never became ready");

	property p_ctrlProtected;
		@(posedge mclk) disable iff (sys_rst)
		loopCtrl_ff.enable |=> $stable(loopCtrl_ff.divFactor) &&
			$stable(loopCtrl_ff.binSearchEn) && $stable(loopCtrl_ff.safeMode) &&
			$stable(loopCtrl_ff.ditherMode);
	endproperty
	a_ctrlProtected: assert property (p_ctrlProtected)
		else $error("protected loop field changed while enabled");

	property p_regsProtected;
		@(posedge mclk) disable iff (sys_rst)
		loopCtrl_ff.enable |=> $stable(ratio_ff) && $stable(dither_ff);
	endproperty
	a_regsProtected: assert property (p_regsProtected)
		else $error("ratio or dither changed while enabled");

	property p_tunerIdle;
		@(posedge mclk) disable iff (sys_rst)
		!loopCtrl_ff.enable |=> $stable(loopTune) && !loopClkEn;
	endproperty
	a_tunerIdle: assert property (p_tunerIdle)
		else $error("tuner active while loop disabled");

	property p_enableWriteTakes;
		@(posedge mclk) disable iff (sys_rst)
		(doWrite && awAddr_ff == OFL_ADDR_LOOP_CTL && !loopCtrl_ff.enable)
			|=> loopCtrl_ff.divFactor == $past(wrMerged[OFL_LC_DIV_LSB +: OFL_DIV_W]);
	endproperty
	a_enableWriteTakes: assert property (p_enableWriteTakes)
		else $error("protected field lost on enabling write");
endmodule

// ==== hw/ofl_pkg.sv ====
// Package: register map, field layout, reset values and types for the oscillator controller
package ofl_pkg;
	// Register byte offsets
	localparam logic [7:0] OFL_ADDR_RC_CTRL  = 8'h00;
	localparam logic [7:0] OFL_ADDR_STATUS   = 8'h04;
	localparam logic [7:0] OFL_ADDR_LOOP_CTL = 8'h08;
	localparam logic [7:0] OFL_ADDR_DITHER   = 8'h0c;
	localparam logic [7:0] OFL_ADDR_RATIO    = 8'h10;
	localparam logic [7:0] OFL_ADDR_TUNE     = 8'h14;
	// rc_osc_control fields
	localparam int OFL_RC_ENABLE_BIT  = 1;
	localparam int OFL_RC_FSEL_LSB    = 2;
	localparam int OFL_RC_STDBY_BIT   = 6;
	localparam int OFL_RC_ONDEM_BIT   = 7;
	localparam logic [1:0] OFL_FSEL_4MHZ = 2'h0;
	// Status fields
	localparam int OFL_ST_RCRDY_BIT   = 4;
	localparam int OFL_ST_LOOPRDY_BIT = 8;
	// loop_control fields
	localparam int OFL_LC_ENABLE_BIT  = 1;
	localparam int OFL_LC_BINARY_SEARCH_ENABLE_BIT   = 2;
	localparam int OFL_LC_SAFE_BIT    = 3;
	localparam int OFL_LC_DITHER_BIT  = 4;
	localparam int OFL_LC_DIV_LSB     = 8;
	// Widths and reset values
	localparam int OFL_DIV_W          = 3;
	localparam int OFL_DITH_W         = 6;
	localparam int OFL_RATIO_W        = 11;
	localparam int OFL_TUNE_W         = 16;
	localparam logic [OFL_RATIO_W-1:0] OFL_RATIO_RST = 11'h000;
	localparam logic [OFL_DITH_W-1:0]  OFL_DITH_RST  = 6'h00;
	// Oscillator start-up delay in cycles before ready
	localparam int OFL_RC_STARTUP_CYC = 8;
	// AXI response codes
	localparam logic [1:0] OFL_RESP_OKAY   = 2'h0;
	localparam logic [1:0] OFL_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OFL_CPU_ACTIVE,
		OFL_CPU_IDLE,
		OFL_CPU_STANDBY
	} ofl_cpu_mode_t;

	typedef struct packed {
		logic       runOnDemand;
		logic       runInStandby;
		logic [1:0] freqSel;
		logic       enable;
	} ofl_rc_ctrl_t;

	typedef struct packed {
		logic [OFL_DIV_W-1:0] divFactor;
		logic                 ditherMode;
		logic                 safeMode;
		logic                 binSearchEn;
		logic                 enable;
	} ofl_loop_ctrl_t;
endpackage

// ==== verification/ofl_clk_partner.sv ====
// Peripheral clock requester and reference tick source for the controller
`timescale 1ns/1ns
module ofl_clk_partner #(
	parameter int REF_DIV  = 16,
	parameter int LOOP_DIV = 3
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Request level chosen by the bench
	input  wire logic reqLvl,
	// Toward the controller
	output logic      periphRequest,
	output logic      refClkTick,
	output logic      loopClkTick
);
	int refCnt;
	int loopCnt;
	// Ticks run free; the controller alone decides whether it tunes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			periphRequest <= 1'b0;
			refCnt        <= 0;
			loopCnt       <= 0;
			refClkTick    <= 1'b0;
			loopClkTick   <= 1'b0;
		end else begin
			periphRequest <= reqLvl;
			refCnt        <= (refCnt == REF_DIV - 1) ? 0 : refCnt + 1;
			loopCnt       <= (loopCnt == LOOP_DIV - 1) ? 0 : loopCnt + 1;
			refClkTick    <= (refCnt == REF_DIV - 1);
			loopClkTick   <= (loopCnt == LOOP_DIV - 1);
		end
	end
endmodule

// ==== verification/ofl_osc_loop_ctrl_tb.sv ====
// Self-checking bench for the oscillator and frequency loop controller
`timescale 1ns/1ns
module ofl_osc_loop_ctrl_tb;
	import ofl_pkg::*;
	localparam int SU = 2;
	logic                  mclk;
	logic                  sys_rst;
	logic [7:0]            awAddr;
	logic [7:0]            arAddr;
	logic [31:0]           wData;
	logic                  awValid, wValid, bReady, arValid, rReady, reqLvl;
	logic                  awReady, wReady, bValid, arReady, rValid;
	logic [1:0]            bResp, rResp, rcOscFreqSel;
	logic [31:0]           rData;
	logic                  rcOscRun, rcOscClkEn, loopClkEn;
	logic                  periphRequest, refClkTick, loopClkTick;
	logic [OFL_TUNE_W-1:0] loopTune;
	ofl_cpu_mode_t         cpuMode;
	int                    n_fail, total_checks, cyc;
	logic [31:0]           seed;

	ofl_osc_loop_ctrl #(.STARTUP_CYC(SU)) ofl_osc_loop_ctrl_i (
		.mclk(mclk), .sys_rst(sys_rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .cpuMode(cpuMode),
		.periphRequest(periphRequest), .refClkTick(refClkTick),
		.loopClkTick(loopClkTick), .rcOscRun(rcOscRun), .rcOscClkEn(rcOscClkEn),
		.rcOscFreqSel(rcOscFreqSel), .loopClkEn(loopClkEn), .loopTune(loopTune));

	ofl_clk_partner ofl_clk_partner_i (
		.mclk(mclk), .sys_rst(sys_rst), .reqLvl(reqLvl),
		.periphRequest(periphRequest), .refClkTick(refClkTick),
		.loopClkTick(loopClkTick));

	always #5 mclk = ~mclk;

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Both bus tasks let one edge pass at the end so no strobe is set twice per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awAddr  <= a;
		wData   <= d;
		awValid <= 1'b1;
		wValid  <= 1'b1;
		bReady  <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bValid) begin
				r = bResp;
				bReady <= 1'b0;
				break;
			end
		end
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		arAddr  <= a;
		arValid <= 1'b1;
		rReady  <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arValid && arReady) arValid <= 1'b0;
			if (rValid) begin
				d = rData;
				r = rResp;
				rReady <= 1'b0;
				break;
			end
		end
		@(posedge mclk);
	endtask

	task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp,
			input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, exp, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic pollReady(input logic lvl);
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		k = 0;
		do begin
			rd(OFL_ADDR_STATUS, d, r);
			k++;
		end while (d[OFL_ST_RCRDY_BIT] !== lvl && k < 50);
		chk("rc_ready", {31'h0, lvl}, {31'h0, d[OFL_ST_RCRDY_BIT]});
	endtask

	initial begin
		int          m, c, i, k;
		logic        ex;
		logic [31:0] d, t, v, lc;
		logic [OFL_TUNE_W-1:0] tn;
		mclk = 1'b0;
		sys_rst = 1'b1;
		{awAddr, arAddr, wData, awValid, wValid, bReady, arValid, rReady, reqLvl} = '0;
		cpuMode = OFL_CPU_ACTIVE;
		seed = 32'h14;
		n_fail = 0;
		total_checks = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		rdChk("rc_ctrl", OFL_ADDR_RC_CTRL, 32'h2, OFL_RESP_OKAY);
		chk("freq_sel", {30'h0, OFL_FSEL_4MHZ}, {30'h0, rcOscFreqSel});
		pollReady(1'b1);
		chk("rc_clk_rst", 32'h1, {31'h0, rcOscClkEn});
		rdChk("loop_ctl", OFL_ADDR_LOOP_CTL, 32'h0, OFL_RESP_OKAY);
		rdChk("dither", OFL_ADDR_DITHER, {26'h0, OFL_DITH_RST}, OFL_RESP_OKAY);
		rdChk("ratio", OFL_ADDR_RATIO, {21'h0, OFL_RATIO_RST}, OFL_RESP_OKAY);
		// Every mode against every enable, standby, on-demand and request level
		for (i = 0; i < 48; i++) begin
			m = i % 3;
			c = i / 3;
			wrChk(OFL_ADDR_RC_CTRL, 32'h0, OFL_RESP_OKAY);
			pollReady(1'b0);
			cpuMode <= ofl_cpu_mode_t'(m);
			reqLvl  <= c[3];
			wrChk(OFL_ADDR_RC_CTRL, {24'h0, c[2], c[1], 4'h0, c[0], 1'b0}, OFL_RESP_OKAY);
			chk("clk_gate", 32'h0, {31'h0, rcOscClkEn});
			ex = c[0] && ((m == 2 && !c[1]) ? c[3] : (!c[2] || c[3]));
			repeat (SU + 6) @(posedge mclk);
			chk("rc_run", {31'h0, ex}, {31'h0, rcOscRun});
			chk("rc_clk", {31'h0, ex}, {31'h0, rcOscClkEn});
		end
		for (k = 0; k < 3; k++) begin
			d = xs();
			t = xs();
			wrChk(OFL_ADDR_DITHER, d, OFL_RESP_OKAY);
			wrChk(OFL_ADDR_RATIO, t, OFL_RESP_OKAY);
			rdChk("dither", OFL_ADDR_DITHER, d & 32'h3f, OFL_RESP_OKAY);
			rdChk("ratio", OFL_ADDR_RATIO, t & 32'h7ff, OFL_RESP_OKAY);
			v = xs() | 32'h2;
			lc = v & 32'h71e;
			wrChk(OFL_ADDR_LOOP_CTL, v, OFL_RESP_OKAY);
			rdChk("loop_ctl", OFL_ADDR_LOOP_CTL, lc, OFL_RESP_OKAY);
			chk("loop_en", 32'h1, {31'h0, loopClkEn});
			wrChk(OFL_ADDR_DITHER, ~d, OFL_RESP_OKAY);
			wrChk(OFL_ADDR_RATIO, ~t, OFL_RESP_OKAY);
			rdChk("dither", OFL_ADDR_DITHER, d & 32'h3f, OFL_RESP_OKAY);
			rdChk("ratio", OFL_ADDR_RATIO, t & 32'h7ff, OFL_RESP_OKAY);
			wrChk(OFL_ADDR_LOOP_CTL, ~v | 32'h2, OFL_RESP_OKAY);
			rdChk("loop_ctl", OFL_ADDR_LOOP_CTL, lc, OFL_RESP_OKAY);
			wrChk(OFL_ADDR_LOOP_CTL, ~v & ~32'h2, OFL_RESP_OKAY);
			rdChk("loop_ctl", OFL_ADDR_LOOP_CTL, lc & ~32'h2, OFL_RESP_OKAY);
			tn = loopTune;
			repeat (40) @(posedge mclk);
			chk("tune_hold", {16'h0, tn}, {16'h0, loopTune});
		end
		// Ratio far above the loop ticks per reference period must pull tune up
		wrChk(OFL_ADDR_RATIO, 32'h7ff, OFL_RESP_OKAY);
		wrChk(OFL_ADDR_LOOP_CTL, 32'h2, OFL_RESP_OKAY);
		tn = loopTune;
		repeat (160) @(posedge mclk);
		chk("tune_up", 32'h1, {31'h0, loopTune > tn});
		// Ratio below the loop ticks per reference period must pull tune down
		wrChk(OFL_ADDR_LOOP_CTL, 32'h0, OFL_RESP_OKAY);
		wrChk(OFL_ADDR_RATIO, 32'h1, OFL_RESP_OKAY);
		wrChk(OFL_ADDR_LOOP_CTL, 32'h2, OFL_RESP_OKAY);
		tn = loopTune;
		repeat (160) @(posedge mclk);
		chk("tune_down", 32'h1, {31'h0, loopTune < tn});
		// Mid-run reset must bring back the oscillator defaults
		cpuMode <= OFL_CPU_ACTIVE;
		wrChk(OFL_ADDR_RC_CTRL, 32'hcc, OFL_RESP_OKAY);
		chk("freq_sel_set", 32'h3, {30'h0, rcOscFreqSel});
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		rdChk("rc_ctrl_rst2", OFL_ADDR_RC_CTRL, 32'h2, OFL_RESP_OKAY);
		rdChk("loop_ctl_rst2", OFL_ADDR_LOOP_CTL, 32'h0, OFL_RESP_OKAY);
		chk("freq_sel_rst2", {30'h0, OFL_FSEL_4MHZ}, {30'h0, rcOscFreqSel});
		pollReady(1'b1);
		chk("rc_clk_rst2", 32'h1, {31'h0, rcOscClkEn});
		wrChk(8'h18, xs(), OFL_RESP_SLVERR);
		rdChk("unmapped", 8'h18, 32'h0, OFL_RESP_SLVERR);
		test_done();
	end
endmodule
